//--- pkg/fkd_pkg.sv
// Constants and types for the flash key and download control block
package fkd_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_KEY = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ARRAY = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 4'hc;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] KEY_DOWNLOAD = 8'ha5;
  localparam logic [7:0] KEY_PROGRAM = 8'h5a;
  localparam logic [7:0] ARRAY_BOOT = 8'haa;
  localparam logic [7:0] ARRAY_USER_RESET = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [6:0] TARGET_MAX = 7'h03;
  localparam int unsigned POS_RANGE_ERR = 7;
  localparam int unsigned POS_REQ = 0;
  localparam int unsigned POS_PROG_SEL = 1;
  localparam int unsigned POS_ERASE_SEL = 2;
  localparam int unsigned POS_BUSY = 3;
  localparam logic [23:0] RAM_BASE0 = 24'hffe080;
  localparam logic [23:0] RAM_BASE1 = 24'hff0800;
  localparam logic [23:0] RAM_BASE2 = 24'hff1800;
  localparam logic [23:0] RAM_BASE3 = 24'hff8800;
  localparam int unsigned COPY_LEN = 16;
  typedef enum logic [1:0] {DL_IDLE, DL_CHECK, DL_COPY} fkd_dl_state_type;
endpackage

//--- src/fkd_copy_engine.sv
// Word copy sequencer that walks a routine into RAM
`timescale 1ns/1ps
module fkd_copy_engine #(
  parameter int unsigned LEN = fkd_pkg::COPY_LEN
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [23:0] base_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             we_o,
  output logic [23:0]      addr_o
);
  import fkd_pkg::*;
  logic [$clog2(LEN+1)-1:0] cnt_r;
  wire last_w = (cnt_r == ($clog2(LEN+1))'(LEN - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      we_o   <= 1'b0;
      addr_o <= 24'h000000;
      cnt_r  <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        we_o   <= 1'b1;
        addr_o <= base_i;
        cnt_r  <= '0;
      end else if (busy_o) begin
        if (last_w) begin
          busy_o <= 1'b0;
          we_o   <= 1'b0;
          done_o <= 1'b1;
        end else begin
          addr_o <= addr_o + 24'h000001;
          cnt_r  <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

//--- src/fkd_top.sv
// Flash key, array select and download control register bank
// What this block does
// RL1 - A one written to the download request bit is taken only while the key register holds A5.
// RL2 - With any key other than A5 an attempt to set the download request is ignored.
// RL3 - Program and erase are enabled only while the key register holds 5A.
// RL4 - Writing AA to the array select register selects the boot array, any other value the user array.
// RL5 - The active array changes right after the array select register is written.
// RL6 - The array select register resets to AA in user boot mode and to 00 otherwise.
// RL7 - Software writes the array select register only while running from RAM; the block takes array select writes whatever ram_exec_i is.
// RL8 - The boot array is never programmable in user program mode, even when selected.
// RL9 - Software loads the target register before requesting a download.
// RL10 - The target register holds the range error flag in bit 7 and a seven-bit area code below it.
// RL11 - The range error flag is set when the area code lies above 03.
// RL12 - The range check happens when a download starts, not when the target register is written.
// RL13 - An out-of-range area code aborts the download and leaves the range error flag set.
// RL14 - Software clears the range error flag and loads a legal code before requesting a download.
// RL15 - A download request copies the chosen routine into RAM, self-clears and always reads zero.
// RL16 - Area codes 0 to 3 map to the RAM start addresses FFE080, FF0800, FF1800 and FF8800.
// RL17 - The key register holds its value until rewritten or reset, and is checked at each gated operation.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module fkd_top #(
  parameter int unsigned COPY_WORDS = fkd_pkg::COPY_LEN
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       boot_mode_i,
  input  wire logic                       user_prog_mode_i,
  input  wire logic                       ram_exec_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [fkd_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]                wb_dat_i,
  input  wire logic [3:0]                 wb_sel_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            boot_array_sel_o,
  output logic                            pe_enable_o,
  output logic                            copy_we_o,
  output logic      [23:0]                copy_addr_o,
  output logic                            copy_prog_o,
  output logic                            download_done_o
);
  import fkd_pkg::*;

  logic [1:0] boot_sync_r;
  logic [1:0] upm_sync_r;
  logic [1:0] ram_sync_r;
  logic       boot_seen_r;
  logic       init_r;
  logic [7:0] key_r;
  logic [7:0] array_r;
  logic [7:0] target_r;
  logic       prog_sel_r;
  logic       erase_sel_r;
  logic       copy_prog_r;
  logic       start_r;
  logic [23:0] base_r;
  fkd_dl_state_type state_r;
  fkd_dl_state_type state_nxt;
  logic       eng_busy;
  logic       eng_done;
  logic       eng_we;
  logic [23:0] eng_addr;

  function automatic logic [23:0] area_base(input logic [6:0] code);
    case (code[1:0])
      2'd0: area_base = RAM_BASE0;
      2'd1: area_base = RAM_BASE1;
      2'd2: area_base = RAM_BASE2;
      default: area_base = RAM_BASE3;
    endcase
  endfunction

  // Bus decode
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w = req_w && wb_we_i && wb_sel_i[0];
  wire wr_key_w = wr_w && (wb_adr_i == OFS_KEY);
  wire wr_ctrl_w = wr_w && (wb_adr_i == OFS_CTRL);
  wire wr_array_w = wr_w && (wb_adr_i == OFS_ARRAY);
  wire wr_target_w = wr_w && (wb_adr_i == OFS_TARGET);
  wire key_dl_ok_w = (key_r == KEY_DOWNLOAD); // RL17
  // Request accepted only with download key, from RAM, when idle
  wire dl_req_w = wr_ctrl_w && wb_dat_i[POS_REQ] && key_dl_ok_w && ram_sync_r[1] && (state_r == DL_IDLE); // RL1 RL2
  wire range_bad_w = (target_r[6:0] > TARGET_MAX); // RL11
  wire boot_sel_w = (array_r == ARRAY_BOOT); // RL4
  wire pe_ok_w = (key_r == KEY_PROGRAM) && !(boot_sel_w && upm_sync_r[1]); // RL3 RL8
  wire [7:0] ctrl_rd_w = {4'h0, (state_r != DL_IDLE), erase_sel_r, prog_sel_r, 1'b0}; // RL15
  wire [7:0] rd_byte_w = (wb_adr_i == OFS_KEY)    ? key_r :
                         (wb_adr_i == OFS_CTRL)   ? ctrl_rd_w :
                         (wb_adr_i == OFS_ARRAY)  ? array_r :
                         (wb_adr_i == OFS_TARGET) ? target_r : 8'h00;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DL_IDLE: begin
        if (dl_req_w) begin
          state_nxt = DL_CHECK;
        end
      end
      DL_CHECK: begin
        if (range_bad_w) begin
          state_nxt = DL_IDLE; // RL13
        end else begin
          state_nxt = DL_COPY;
        end
      end
      DL_COPY: begin
        if (eng_done) begin
          state_nxt = DL_IDLE;
        end
      end
      default: state_nxt = DL_IDLE;
    endcase
  end

  // Synchronisers run through reset so the strap is settled at release
  always_ff @(posedge clk_i) begin
    boot_sync_r <= {boot_sync_r[0], boot_mode_i};
    upm_sync_r  <= {upm_sync_r[0], user_prog_mode_i};
    ram_sync_r  <= {ram_sync_r[0], ram_exec_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req_w;
      wb_dat_o <= req_w ? {24'h000000, rd_byte_w} : 32'h00000000;
    end
  end

  // Boot strap caught after reset release, applied once to array select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_r      <= 1'b1;
      boot_seen_r <= 1'b0;
      key_r       <= KEY_RESET;
      array_r     <= ARRAY_USER_RESET;
    end else begin
      init_r <= 1'b0;
      if (wr_key_w) begin
        key_r <= wb_dat_i[7:0]; // RL17
      end
      if (wr_array_w) begin
        array_r <= wb_dat_i[7:0]; // RL5
      end else if (init_r && boot_sync_r[1]) begin
        array_r     <= ARRAY_BOOT; // RL6
        boot_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_r    <= TARGET_RESET;
      prog_sel_r  <= 1'b0;
      erase_sel_r <= 1'b0;
      copy_prog_r <= 1'b0;
      start_r     <= 1'b0;
      base_r      <= 24'h000000;
      state_r     <= DL_IDLE;
    end else begin
      state_r <= state_nxt;
      start_r <= 1'b0;
      if (wr_target_w) begin
        target_r <= wb_dat_i[7:0]; // RL10
      end
      if (state_r == DL_CHECK && range_bad_w) begin
        target_r[POS_RANGE_ERR] <= 1'b1; // RL12 RL13
      end
      if (wr_ctrl_w && state_r == DL_IDLE) begin
        prog_sel_r  <= wb_dat_i[POS_PROG_SEL];
        erase_sel_r <= wb_dat_i[POS_ERASE_SEL];
      end else if (eng_done) begin
        prog_sel_r  <= 1'b0;
        erase_sel_r <= 1'b0;
      end
      if (state_r == DL_CHECK && !range_bad_w) begin
        start_r     <= 1'b1; // RL15
        base_r      <= area_base(target_r[6:0]); // RL16
        copy_prog_r <= prog_sel_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_array_sel_o <= 1'b0;
      pe_enable_o      <= 1'b0;
      download_done_o  <= 1'b0;
      copy_prog_o      <= 1'b0;
    end else begin
      boot_array_sel_o <= boot_sel_w; // RL4
      pe_enable_o      <= pe_ok_w; // RL3
      download_done_o  <= eng_done;
      copy_prog_o      <= copy_prog_r;
    end
  end

  fkd_copy_engine #(
    .LEN(COPY_WORDS)
  ) u_copy (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .start_i(start_r),
    .base_i (base_r),
    .busy_o (eng_busy),
    .done_o (eng_done),
    .we_o   (eng_we),
    .addr_o (eng_addr)
  );

  assign copy_we_o = eng_we;
  assign copy_addr_o = eng_addr;

  // Checks
  property p_req_needs_key;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == DL_IDLE && $past(state_r) == DL_IDLE && state_nxt == DL_CHECK) |-> key_r == KEY_DOWNLOAD;
  endproperty
  a_req_needs_key: assert property (p_req_needs_key) else $error("download started without key"); // RL1

  property p_bad_key_ignored;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ctrl_w && wb_dat_i[POS_REQ] && key_r != KEY_DOWNLOAD) |=> state_r == DL_IDLE || $past(state_r) != DL_IDLE;
  endproperty
  a_bad_key_ignored: assert property (p_bad_key_ignored) else $error("request taken with wrong key"); // RL2

  property p_pe_key;
    @(posedge clk_i) disable iff (rst_i)
      pe_enable_o |-> $past(key_r) == KEY_PROGRAM;
  endproperty
  a_pe_key: assert property (p_pe_key) else $error("program enabled without key"); // RL3

  property p_boot_nolock;
    @(posedge clk_i) disable iff (rst_i)
      (pe_enable_o && $past(upm_sync_r[1])) |-> !$past(boot_sel_w);
  endproperty
  a_boot_nolock: assert property (p_boot_nolock) else $error("boot array programmable in user mode"); // RL8

  property p_array_switch;
    @(posedge clk_i) disable iff (rst_i)
      wr_array_w |=> ##1 boot_array_sel_o == ($past(wb_dat_i[7:0], 2) == ARRAY_BOOT);
  endproperty
  a_array_switch: assert property (p_array_switch) else $error("array select did not follow write"); // RL4 RL5

  property p_range_abort;
    @(posedge clk_i) disable iff (rst_i)
      (state_r == DL_CHECK && range_bad_w && !wr_target_w) |=> target_r[POS_RANGE_ERR] && state_r == DL_IDLE && !start_r;
  endproperty
  a_range_abort: assert property (p_range_abort) else $error("out of range download not aborted"); // RL11 RL13

  property p_no_write_check;
    @(posedge clk_i) disable iff (rst_i)
      (wr_target_w && state_r == DL_IDLE) |=> target_r == $past(wb_dat_i[7:0]);
  endproperty
  a_no_write_check: assert property (p_no_write_check) else $error("target changed on write"); // RL12

  property p_copy_done;
    @(posedge clk_i) disable iff (rst_i)
      start_r |=> ##[1:1000] eng_done;
  endproperty
  a_copy_done: assert property (p_copy_done) else $error("copy never finished"); // RL15

  property p_req_reads_zero;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(wb_adr_i) == OFS_CTRL && !$past(wb_we_i) |-> wb_dat_o[POS_REQ] == 1'b0;
  endproperty
  a_req_reads_zero: assert property (p_req_reads_zero) else $error("request bit read as one"); // RL15

  property p_base_map;
    @(posedge clk_i) disable iff (rst_i)
      start_r |-> base_r == area_base($past(target_r[6:0]));
  endproperty
  a_base_map: assert property (p_base_map) else $error("wrong ram base"); // RL16

  property p_key_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_key_w |=> key_r == $past(key_r);
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("key changed without write"); // RL17

  property p_key_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_key_w |=> key_r == $past(wb_dat_i[7:0]);
  endproperty
  a_key_write: assert property (p_key_write) else $error("key write lost"); // RL17

  property p_pe_off;
    @(posedge clk_i) disable iff (rst_i)
      (key_r != KEY_PROGRAM) |=> !pe_enable_o;
  endproperty
  a_pe_off: assert property (p_pe_off) else $error("program enable stayed on"); // RL3

  property p_boot_strap;
    @(posedge clk_i) disable iff (rst_i)
      (init_r && boot_sync_r[1] && !wr_array_w) |=> array_r == ARRAY_BOOT && boot_seen_r;
  endproperty
  a_boot_strap: assert property (p_boot_strap) else $error("boot strap not applied"); // RL6

  property p_array_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!wr_array_w && !init_r) |=> array_r == $past(array_r);
  endproperty
  a_array_hold: assert property (p_array_hold) else $error("array select changed without write"); // RL5

  property p_busy_copy;
    @(posedge clk_i) disable iff (rst_i)
      eng_busy |-> state_r == DL_COPY;
  endproperty
  a_busy_copy: assert property (p_busy_copy) else $error("copy outside download"); // RL15

  property p_sel_clear;
    @(posedge clk_i) disable iff (rst_i)
      eng_done |=> !prog_sel_r && !erase_sel_r;
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("routine select not cleared"); // RL15

  property p_check_once;
    @(posedge clk_i) disable iff (rst_i)
      state_r == DL_CHECK |=> state_r != DL_CHECK;
  endproperty
  a_check_once: assert property (p_check_once) else $error("range check repeated"); // RL12

  property p_start_in_range;
    @(posedge clk_i) disable iff (rst_i)
      start_r |-> $past(target_r[6:0]) <= TARGET_MAX;
  endproperty
  a_start_in_range: assert property (p_start_in_range) else $error("copy started out of range"); // RL11 RL13

  property p_target_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!wr_target_w && state_r != DL_CHECK) |=> target_r == $past(target_r);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target changed outside check"); // RL12

  property p_done_pulse;
    @(posedge clk_i) disable iff (rst_i)
      download_done_o |=> !download_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // RL15

  c_download: cover property (@(posedge clk_i) disable iff (rst_i) eng_done);
  c_boot_strap: cover property (@(posedge clk_i) disable iff (rst_i) boot_seen_r);
  c_abort: cover property (@(posedge clk_i) disable iff (rst_i) state_r == DL_CHECK && range_bad_w);
  c_boot_sel: cover property (@(posedge clk_i) disable iff (rst_i) boot_array_sel_o);
  c_pe_on: cover property (@(posedge clk_i) disable iff (rst_i) pe_enable_o);
endmodule

//--- sim/testbench.sv
// Self-checking bench for the flash key and download control block
`timescale 1ns/1ps
module testbench;
  import fkd_pkg::*;
  localparam int unsigned NW = 4;
  localparam logic [23:0] BASES [4] = '{RAM_BASE0, RAM_BASE1, RAM_BASE2, RAM_BASE3};
  logic              clk_i            = 1'b0;
  logic              rst_i            = 1'b1;
  logic              boot_mode_i      = 1'b0;
  logic              user_prog_mode_i = 1'b0;
  logic              ram_exec_i       = 1'b0;
  logic              wb_cyc_i         = 1'b0;
  logic              wb_stb_i         = 1'b0;
  logic              wb_we_i          = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i         = '0;
  logic [31:0]       wb_dat_i         = '0;
  logic [3:0]        wb_sel_i         = '0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              boot_array_sel_o;
  logic              pe_enable_o;
  logic              copy_we_o;
  logic [23:0]       copy_addr_o;
  logic              copy_prog_o;
  logic              download_done_o;
  int                n_errors = 0;
  int                checked  = 0;
  int                n_done   = 0;
  logic [23:0]       addr_q[$];
  logic              prog_seen;
  logic [31:0]       rd;

  fkd_top #(.COPY_WORDS(NW)) u_dut (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .boot_mode_i      (boot_mode_i),
    .user_prog_mode_i (user_prog_mode_i),
    .ram_exec_i       (ram_exec_i),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_dat_i         (wb_dat_i),
    .wb_sel_i         (wb_sel_i),
    .wb_dat_o         (wb_dat_o),
    .wb_ack_o         (wb_ack_o),
    .boot_array_sel_o (boot_array_sel_o),
    .pe_enable_o      (pe_enable_o),
    .copy_we_o        (copy_we_o),
    .copy_addr_o      (copy_addr_o),
    .copy_prog_o      (copy_prog_o),
    .download_done_o  (download_done_o)
  );

  always #12.5 clk_i = ~clk_i;

  // Record copy traffic
  always @(posedge clk_i) begin
    if (copy_we_o === 1'b1) begin
      addr_q.push_back(copy_addr_o);
      prog_seen = copy_prog_o;
    end
    if (download_done_o === 1'b1) begin
      n_done++;
    end
  end

  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t pin %b expected %b", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single Wishbone cycle
  task automatic wb_io(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wb_io(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    wb_io(1'b0, a, 8'h00);
    chk_reg({24'h0, e}, rd);
  endtask

  // Load target, request, then compare copy traffic
  task automatic dl(input logic [7:0] tgt, input logic [7:0] ctl, input int exp_n, input logic [23:0] base);
    addr_q.delete();
    n_done = 0;
    wr(OFS_TARGET, tgt);
    wr(OFS_CTRL, ctl);
    tick(NW + 12);
    chk_reg(exp_n, addr_q.size());
    chk_reg((exp_n == 0) ? 0 : 1, n_done);
    for (int i = 0; i < exp_n; i++) begin
      chk_reg(base + i, addr_q[i]);
    end
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    tick(10);
    rst_i <= 1'b0;
    tick(4);
  endtask

  initial begin
    #500000;
    n_errors++;
    give_verdict;
  end

  initial begin
    do_reset;
    rd_chk(OFS_KEY, KEY_RESET);
    rd_chk(OFS_ARRAY, ARRAY_USER_RESET);
    rd_chk(OFS_TARGET, TARGET_RESET);
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(4'h2, 8'h00);
    $display("test reset values done");
    ram_exec_i <= 1'b1;
    tick(5);
    dl(8'h01, 8'h03, 0, 24'h0);
    wr(OFS_KEY, KEY_PROGRAM);
    dl(8'h01, 8'h03, 0, 24'h0);
    wr(OFS_KEY, KEY_DOWNLOAD);
    for (int c = 0; c < 4; c++) begin
      dl(c[7:0], 8'h03, NW, BASES[c]);
      chk_pin(1'b1, prog_seen);
    end
    wr(OFS_TARGET, 8'h01);
    wr(OFS_CTRL, 8'h03);
    wr(OFS_CTRL, 8'h05);
    rd_chk(OFS_CTRL, 8'h0a);
    tick(NW + 12);
    dl(8'h02, 8'h05, NW, RAM_BASE2);
    chk_pin(1'b0, prog_seen);
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(OFS_KEY, KEY_DOWNLOAD);
    ram_exec_i <= 1'b0;
    tick(5);
    dl(8'h00, 8'h03, 0, 24'h0);
    ram_exec_i <= 1'b1;
    tick(5);
    $display("test download gating done");
    wr(OFS_TARGET, 8'h04);
    rd_chk(OFS_TARGET, 8'h04);
    dl(8'h04, 8'h03, 0, 24'h0);
    rd_chk(OFS_TARGET, 8'h84);
    dl(8'h7f, 8'h03, 0, 24'h0);
    rd_chk(OFS_TARGET, 8'hff);
    dl(8'h03, 8'h03, NW, RAM_BASE3);
    rd_chk(OFS_TARGET, 8'h03);
    $display("test range check done");
    wr(OFS_KEY, KEY_PROGRAM);
    chk_pin(1'b1, pe_enable_o);
    wr(OFS_KEY, 8'h5b);
    chk_pin(1'b0, pe_enable_o);
    wr(OFS_KEY, KEY_PROGRAM);
    wr(OFS_ARRAY, ARRAY_BOOT);
    chk_pin(1'b1, boot_array_sel_o);
    rd_chk(OFS_ARRAY, ARRAY_BOOT);
    chk_pin(1'b1, pe_enable_o);
    user_prog_mode_i <= 1'b1;
    tick(5);
    chk_pin(1'b0, pe_enable_o);
    wr(OFS_ARRAY, 8'hab);
    chk_pin(1'b0, boot_array_sel_o);
    tick(2);
    chk_pin(1'b1, pe_enable_o);
    user_prog_mode_i <= 1'b0;
    $display("test array and protection done");
    boot_mode_i <= 1'b1;
    tick(3);
    do_reset;
    rd_chk(OFS_ARRAY, ARRAY_BOOT);
    chk_pin(1'b1, boot_array_sel_o);
    rd_chk(OFS_KEY, KEY_RESET);
    $display("test boot mode reset done");
    give_verdict;
  end
endmodule
